/* File: design/scfifo_defines.svh */
// Constants for the single-clock FIFO: geometry, register map, fields, reset values
`ifndef SCFIFO_DEFINES_SVH
`define SCFIFO_DEFINES_SVH
`define SCF_DW 18
`define SCF_AW 10
`define SCF_CW 11
`define SCF_DEPTH 11'h400
`define SCF_AFULL_GAP 11'h002
`define SCF_RA_W 4
`define SCF_OFS_CTRL 4'h0
`define SCF_OFS_AE_THR 4'h1
`define SCF_OFS_STATUS 4'h2
`define SCF_OFS_IRQ_STAT 4'h3
`define SCF_OFS_IRQ_MASK 4'h4
`define SCF_CTRL_MODE_LSB 0
`define SCF_CTRL_MODE_MSB 1
`define SCF_ST_EMPTY 0
`define SCF_ST_AEMPTY 1
`define SCF_ST_AFULL 2
`define SCF_ST_FULL 3
`define SCF_ST_CNT_LSB 16
`define SCF_ST_CNT_MSB 26
`define SCF_EV_FULL 0
`define SCF_EV_AFULL 1
`define SCF_EV_EMPTY 2
`define SCF_EV_AEMPTY 3
`define SCF_EV_OVERFLOW 4
`define SCF_EV_UNDERFLOW 5
`define SCF_EV_W 6
`define SCF_RST_MODE 2'h0
`define SCF_RST_AE_THR 11'h003
`define SCF_RST_MASK 6'h00
`endif

/* File: design/scfifo_pkg.sv */
// Types shared by the single-clock FIFO
`include "scfifo_defines.svh"
package scfifo_pkg;
	typedef enum logic [1:0] {
		SCF_OUT_NONE,
		SCF_OUT_REG,
		SCF_OUT_REG_RE
	} scf_out_mode_type;
	typedef struct packed {
		logic full;
		logic afull;
		logic aempty;
		logic empty;
	} scf_flags_type;
	typedef struct packed {
		logic [`SCF_RA_W-1:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} scf_bus_req_type;
endpackage : scfifo_pkg

/* File: design/scfifo_top.sv */
// Single-clock FIFO on a block RAM with flag logic, output stage options and register port
// What this block does
// - One clock, reset, requests, data, four flags
// - Block RAM storage, counters and flags around
// - Empty FIFO: empty, almost empty high
// - Empty drops after first word written
// - Almost empty drops at threshold fill
// - Almost full asserts at location N-2
// - Full asserts when last word written
// - Writes while full are discarded
// - Read request returns words in order
// - Reading clears full and almost full
// - Draining sets almost empty then empty
// - Output register adds one cycle delay
// - Output register leaves flag timing alone
// - Output register may be read-gated
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "scfifo_defines.svh"
module scfifo_top (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_write_request,
	input wire logic [`SCF_DW-1:0] i_wr_data,
	input wire logic i_read_request,
	output logic [`SCF_DW-1:0] o_rd_data,
	output logic o_full,
	output logic o_almost_full,
	output logic o_empty,
	output logic o_almost_empty,
	input wire logic [`SCF_RA_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_we,
	input wire logic i_reg_re,
	output logic [31:0] o_reg_rdata,
	output logic o_irq
);

	// Block RAM body; never reset so it maps onto a RAM macro
	logic [`SCF_DW-1:0] mem [0:`SCF_DEPTH-1];

	logic [`SCF_AW-1:0] wr_ptr_ff;
	logic [`SCF_AW-1:0] rd_ptr_ff;
	logic [`SCF_CW-1:0] cnt_ff;
	scfifo_pkg::scf_flags_type flags_ff;
	logic [`SCF_DW-1:0] ram_q_ff;
	logic [`SCF_DW-1:0] out_q_ff;
	logic stage_pend_ff;
	scfifo_pkg::scf_out_mode_type mode_ff;
	logic [`SCF_CW-1:0] ae_thr_ff;
	logic [`SCF_EV_W-1:0] irq_stat_ff;
	logic [`SCF_EV_W-1:0] irq_mask_ff;
	logic irq_ff;
	logic [31:0] reg_rdata_ff;

	wire scfifo_pkg::scf_bus_req_type bus;
	wire logic wr_ok;
	wire logic rd_ok;
	wire logic [`SCF_AW-1:0] nxt_wr_ptr;
	wire logic [`SCF_AW-1:0] nxt_rd_ptr;
	wire logic [`SCF_CW-1:0] nxt_cnt;
	wire scfifo_pkg::scf_flags_type nxt_flags;
	wire logic [`SCF_EV_W-1:0] events;
	wire logic [`SCF_EV_W-1:0] nxt_irq_stat;
	wire logic [`SCF_EV_W-1:0] w1c_bits;
	wire logic sel_ctrl;
	wire logic sel_thr;
	wire logic sel_status;
	wire logic sel_stat;
	wire logic sel_mask;
	wire logic [31:0] ctrl_word;
	wire logic [31:0] status_word;
	wire logic [31:0] rd_word;
	wire logic stage_load;
	wire logic [`SCF_DW-1:0] nxt_out_q;

	// Unused codes fall back to the unregistered path rather than a dead mode
	function automatic scfifo_pkg::scf_out_mode_type decode_mode(input logic [1:0] code);
		scfifo_pkg::scf_out_mode_type m;
		m = scfifo_pkg::SCF_OUT_NONE;
		if (code == 2'h1) begin
			m = scfifo_pkg::SCF_OUT_REG;
		end else if (code == 2'h2) begin
			m = scfifo_pkg::SCF_OUT_REG_RE;
		end
		return m;
	endfunction : decode_mode

	// Flags follow occupancy and the almost-empty threshold only, so every output mode sees the same timing
	function automatic scfifo_pkg::scf_flags_type calc_flags(
		input logic [`SCF_CW-1:0] cnt,
		input logic [`SCF_CW-1:0] thr
	);
		scfifo_pkg::scf_flags_type f;
		f.empty = (cnt == `SCF_CW'h000);
		f.aempty = (cnt < thr);
		f.afull = (cnt >= (`SCF_DEPTH - `SCF_AFULL_GAP));
		f.full = (cnt == `SCF_DEPTH);
		return f;
	endfunction : calc_flags

	assign bus.addr = i_reg_addr;
	assign bus.wdata = i_reg_wdata;
	assign bus.we = i_reg_we;
	assign bus.re = i_reg_re;

	assign wr_ok = i_write_request & ~flags_ff.full;
	assign rd_ok = i_read_request & ~flags_ff.empty;

	assign nxt_wr_ptr = wr_ok ? wr_ptr_ff + `SCF_AW'h001 : wr_ptr_ff;
	assign nxt_rd_ptr = rd_ok ? rd_ptr_ff + `SCF_AW'h001 : rd_ptr_ff;
	assign nxt_cnt = cnt_ff + {{(`SCF_CW-1){1'b0}}, wr_ok} - {{(`SCF_CW-1){1'b0}}, rd_ok};

	assign nxt_flags = calc_flags(nxt_cnt, ae_thr_ff);

	assign events[`SCF_EV_FULL] = nxt_flags.full & ~flags_ff.full;
	assign events[`SCF_EV_AFULL] = nxt_flags.afull & ~flags_ff.afull;
	assign events[`SCF_EV_EMPTY] = nxt_flags.empty & ~flags_ff.empty;
	assign events[`SCF_EV_AEMPTY] = nxt_flags.aempty & ~flags_ff.aempty;
	assign events[`SCF_EV_OVERFLOW] = i_write_request & flags_ff.full;
	assign events[`SCF_EV_UNDERFLOW] = i_read_request & flags_ff.empty;

	assign sel_ctrl = (bus.addr == `SCF_OFS_CTRL);
	assign sel_thr = (bus.addr == `SCF_OFS_AE_THR);
	assign sel_status = (bus.addr == `SCF_OFS_STATUS);
	assign sel_stat = (bus.addr == `SCF_OFS_IRQ_STAT);
	assign sel_mask = (bus.addr == `SCF_OFS_IRQ_MASK);

	// A new event in the clearing cycle survives the write-one-to-clear
	assign w1c_bits = (bus.we & sel_stat) ? bus.wdata[`SCF_EV_W-1:0] : `SCF_EV_W'h00;
	assign nxt_irq_stat = (irq_stat_ff & ~w1c_bits) | events;

	assign ctrl_word = {30'h00000000, mode_ff};
	assign status_word = {5'h00, cnt_ff, 12'h000,
		flags_ff.full, flags_ff.afull, flags_ff.aempty, flags_ff.empty};
	assign rd_word = sel_ctrl ? ctrl_word :
		sel_thr ? {21'h000000, ae_thr_ff} :
		sel_status ? status_word :
		sel_stat ? {26'h0000000, irq_stat_ff} :
		sel_mask ? {26'h0000000, irq_mask_ff} :
		32'h00000000;

	assign stage_load = (mode_ff == scfifo_pkg::SCF_OUT_REG) |
		((mode_ff == scfifo_pkg::SCF_OUT_REG_RE) & i_read_request & stage_pend_ff);

	assign nxt_out_q = (mode_ff == scfifo_pkg::SCF_OUT_NONE) ? (rd_ok ? mem[rd_ptr_ff] : out_q_ff) :
		(stage_load ? ram_q_ff : out_q_ff);

	always_ff @(posedge i_clk) begin
		if (wr_ok) begin
			mem[wr_ptr_ff] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr_ff <= `SCF_AW'h000;
			rd_ptr_ff <= `SCF_AW'h000;
			cnt_ff <= `SCF_CW'h000;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			flags_ff <= '{full: 1'b0, afull: 1'b0, aempty: 1'b1, empty: 1'b1};
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// RAM port register; holds its word until the next pop
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ram_q_ff <= `SCF_DW'h00000;
		end else if (rd_ok) begin
			ram_q_ff <= mem[rd_ptr_ff];
		end
	end

	// Marks a RAM word not yet moved into the gated stage
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stage_pend_ff <= 1'b0;
		end else if (rd_ok) begin
			stage_pend_ff <= 1'b1;
		end else if (stage_load) begin
			stage_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			out_q_ff <= `SCF_DW'h00000;
		end else begin
			out_q_ff <= nxt_out_q;
		end
	end

	// Mode is meant to change only while idle; a change mid-stream mixes latencies
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_ff <= scfifo_pkg::scf_out_mode_type'(`SCF_RST_MODE);
		end else if (bus.we & sel_ctrl) begin
			mode_ff <= decode_mode(bus.wdata[`SCF_CTRL_MODE_MSB:`SCF_CTRL_MODE_LSB]);
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ae_thr_ff <= `SCF_RST_AE_THR;
		end else if (bus.we & sel_thr) begin
			ae_thr_ff <= bus.wdata[`SCF_CW-1:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_mask_ff <= `SCF_RST_MASK;
		end else if (bus.we & sel_mask) begin
			irq_mask_ff <= bus.wdata[`SCF_EV_W-1:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_stat_ff <= `SCF_EV_W'h00;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	// Registered so the pin is glitch free; built from the next status, so it changes on the same edge as the status
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	// Read data stands for one cycle only, zero otherwise
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			reg_rdata_ff <= 32'h00000000;
		end else if (bus.re) begin
			reg_rdata_ff <= rd_word;
		end else begin
			reg_rdata_ff <= 32'h00000000;
		end
	end

	assign o_full = flags_ff.full;
	assign o_almost_full = flags_ff.afull;
	assign o_empty = flags_ff.empty;
	assign o_almost_empty = flags_ff.aempty;
	assign o_rd_data = out_q_ff;
	assign o_reg_rdata = reg_rdata_ff;
	assign o_irq = irq_ff;

endmodule : scfifo_top

/* File: tb/scf_chk.sv */
// Checker for FIFO flags, reset state and read data timing
`timescale 1ns/1ps
`include "scfifo_defines.svh"
module scf_chk (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_write_request,
	input wire logic i_read_request,
	input wire logic [`SCF_DW-1:0] o_rd_data,
	input wire logic o_full,
	input wire logic o_almost_full,
	input wire logic o_empty,
	input wire logic o_almost_empty,
	input wire logic [31:0] o_reg_rdata,
	input wire logic o_irq
);
	logic [10:0] occ_ff;
	wire do_wr = i_write_request && !o_full;
	wire do_rd = i_read_request && !o_empty;
	// Occupancy mirror; the almost-empty check against it holds only while the threshold stays at reset value
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) occ_ff <= 11'h0;
		else occ_ff <= occ_ff + 11'(do_wr) - 11'(do_rd);
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	property p_empty; o_empty == (occ_ff == 11'h0); endproperty
	a_empty: assert property (p_empty) else $error("empty flag");
	property p_aempty; o_almost_empty == (occ_ff < 11'h3); endproperty
	a_aempty: assert property (p_aempty) else $error("almost empty flag");
	property p_afull; o_almost_full == (occ_ff >= 11'h3fe); endproperty
	a_afull: assert property (p_afull) else $error("almost full flag");
	property p_full; o_full == (occ_ff == 11'h400); endproperty
	a_full: assert property (p_full) else $error("full flag");
	property p_drop; o_full && i_write_request && !i_read_request |=> o_full && o_almost_full; endproperty
	a_drop: assert property (p_drop) else $error("write while full");
	property p_under; o_empty && i_read_request && !i_write_request |=> o_empty && o_almost_empty; endproperty
	a_under: assert property (p_under) else $error("read while empty");
	property p_rst; $rose(i_nrst) |-> o_empty && o_almost_empty && !o_full && !o_almost_full && !o_irq; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_rdat; $changed(o_rd_data) |-> $past(i_read_request) || $past(i_read_request, 2); endproperty
	a_rdat: assert property (p_rdat) else $error("read data without request");
	c_full: cover property (o_full && i_write_request);
	c_under: cover property (o_empty && i_read_request);
	c_irq: cover property (o_irq);
endmodule : scf_chk

/* File: tb/scf_user.sv */
// User-side producer and consumer that feed the FIFO
`timescale 1ns/1ps
`include "scfifo_defines.svh"
module scf_user (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_wr_go,
	input wire logic i_rd_go,
	input wire logic i_full,
	output logic o_write_request,
	output logic [`SCF_DW-1:0] o_wr_data,
	output logic o_read_request
);
	logic [`SCF_DW-1:0] word_ff;
	wire [`SCF_DW-1:0] nxt_word = word_ff + 18'h1;
	assign o_write_request = i_wr_go;
	// Idle data is scrambled so a stale word never passes for a fresh one
	assign o_wr_data = i_wr_go ? word_ff : ~word_ff;
	assign o_read_request = i_rd_go;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) word_ff <= 18'h0;
		else if (i_wr_go && !i_full) word_ff <= nxt_word;
	end
endmodule : scf_user

/* File: tb/tb_single_clock_fifo.sv */
// Testbench for the single-clock FIFO with its user-side partner
`timescale 1ns/1ps
`include "scfifo_defines.svh"
module tb_single_clock_fifo;
	logic i_clk = 1'h0;
	logic i_nrst = 1'h0;
	logic wr_go = 1'h0;
	logic rd_go = 1'h0;
	logic [3:0] i_reg_addr = 4'h0;
	logic [31:0] i_reg_wdata = 32'h0;
	logic i_reg_we = 1'h0;
	logic i_reg_re = 1'h0;
	logic i_write_request, i_read_request, o_full, o_almost_full, o_empty, o_almost_empty, o_irq;
	logic [`SCF_DW-1:0] i_wr_data, o_rd_data;
	logic [31:0] o_reg_rdata;
	int fails = 0;
	int checks = 0;
	int wn = 0;
	always #4 i_clk = ~i_clk;
	scfifo_top i_dut (.i_clk, .i_nrst, .i_write_request, .i_wr_data, .i_read_request, .o_rd_data, .o_full,
		.o_almost_full, .o_empty, .o_almost_empty, .i_reg_addr, .i_reg_wdata, .i_reg_we, .i_reg_re,
		.o_reg_rdata, .o_irq);
	scf_user i_user (.i_clk, .i_nrst, .i_wr_go(wr_go), .i_rd_go(rd_go), .i_full(o_full),
		.o_write_request(i_write_request), .o_wr_data(i_wr_data), .o_read_request(i_read_request));
	task chk(input logic ok, input string msg);
		checks++;
		if (!ok) begin
			fails++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask : chk
	task close_out;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_reg_we <= 1'h1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_we <= 1'h0;
	endtask : reg_wr
	task reg_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_reg_re <= 1'h1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_re <= 1'h0;
		#1 chk(o_reg_rdata === e, "register read");
	endtask : reg_rd
	task push(input int n);
		@(posedge i_clk);
		wr_go <= 1'h1;
		repeat (n) @(posedge i_clk);
		wr_go <= 1'h0;
		#1;
	endtask : push
	task t_reset;
		@(posedge i_clk);
		i_nrst <= 1'h0;
		repeat (11) @(posedge i_clk);
		i_nrst <= 1'h1;
		#1 chk(o_empty === 1'h1 && o_almost_empty === 1'h1 && o_full === 1'h0 && o_rd_data === 18'h0, "reset");
	endtask : t_reset
	task t_fill;
		push(1);
		chk(o_empty === 1'h0 && o_almost_empty === 1'h1, "first word");
		push(2);
		chk(o_almost_empty === 1'h0, "third word");
		push(1018);
		chk(o_almost_full === 1'h0, "below N-2");
		push(1);
		chk(o_almost_full === 1'h1 && o_full === 1'h0, "at N-2");
		push(2);
		chk(o_full === 1'h1, "full");
		push(3);
		reg_rd(`SCF_OFS_STATUS, 32'h0400000c);
		wn = 1024;
	endtask : t_fill
	task t_drain;
		@(posedge i_clk);
		rd_go <= 1'h1;
		for (int k = 0; k < 1024; k++) begin
			@(posedge i_clk);
			if (k == 1023) rd_go <= 1'h0;
			#1 chk(o_rd_data === 18'(k), "order");
			if (k == 0) chk(o_full === 1'h0 && o_almost_full === 1'h1, "full off");
			if (k == 2) chk(o_almost_full === 1'h0, "afull off");
		end
		chk(o_empty === 1'h1 && o_almost_empty === 1'h1, "drained");
	endtask : t_drain
	task t_irq;
		@(posedge i_clk);
		rd_go <= 1'h1;
		@(posedge i_clk);
		rd_go <= 1'h0;
		reg_rd(`SCF_OFS_STATUS, 32'h3);
		reg_rd(`SCF_OFS_IRQ_STAT, 32'h3f);
		reg_wr(`SCF_OFS_IRQ_MASK, 32'h20);
		@(posedge i_clk);
		#1 chk(o_irq === 1'h1, "irq set");
		reg_wr(`SCF_OFS_IRQ_STAT, 32'h20);
		@(posedge i_clk);
		#1 chk(o_irq === 1'h0, "irq clear");
		reg_rd(4'hf, 32'h0);
		reg_rd(`SCF_OFS_AE_THR, 32'h3);
		reg_wr(`SCF_OFS_CTRL, 32'h3);
		reg_rd(`SCF_OFS_CTRL, 32'h0);
	endtask : t_irq
	task t_lat(input logic [1:0] m, input int hold, input int lat);
		int got;
		got = 0;
		reg_wr(`SCF_OFS_CTRL, {30'h0, m});
		reg_rd(`SCF_OFS_CTRL, {30'h0, m});
		push(1);
		@(posedge i_clk);
		rd_go <= 1'h1;
		for (int k = 1; k <= 3; k++) begin
			@(posedge i_clk);
			if (k == hold) rd_go <= 1'h0;
			#1 if (o_rd_data === 18'(wn) && got == 0) got = k;
		end
		// A word left in the gated stage moves only on the next request
		if (lat == 0) begin
			@(posedge i_clk);
			rd_go <= 1'h1;
			@(posedge i_clk);
			rd_go <= 1'h0;
			#1 got = (o_rd_data === 18'(wn)) ? 0 : 9;
		end
		chk(got == lat, "read latency");
		wn++;
	endtask : t_lat
	initial begin
		repeat (20000) @(posedge i_clk);
		fails++;
		close_out();
	end
	initial begin
		t_reset();
		t_fill();
		t_drain();
		t_irq();
		t_lat(2'h0, 1, 1);
		t_lat(2'h1, 1, 2);
		t_lat(2'h2, 2, 2);
		t_lat(2'h2, 1, 0);
		push(3);
		t_reset();
		close_out();
	end
endmodule : tb_single_clock_fifo
bind scfifo_top scf_chk i_chk (.i_clk, .i_nrst, .i_write_request, .i_read_request, .o_rd_data, .o_full,
	.o_almost_full, .o_empty, .o_almost_empty, .o_reg_rdata, .o_irq);
